// ===== design/remote_port_cfg.svh
// Constants for the remote program port: polarities, codes and widths
`ifndef REMOTE_PORT_CFG_SVH
`define REMOTE_PORT_CFG_SVH

`define RANGE_W           3
`define MODE_W            2
`define DATA_W            16
`define STATUS_W          4
`define RANGE_HOLD_CODE   3'h0
`define STROBE_IDLE       1'h1
`define STROBE_ACTIVE     1'h0
`define OUT_INACTIVE      1'h1

`endif

// ===== design/remote_port_pkg.sv
// Types for the remote program port
package remote_port_pkg;

    // Remote programming inputs, all as received at the connector
    typedef struct packed {
        logic [2:0] range_bits;
        logic [1:0] mode_bits;
        logic       cal_factor_disable;
        logic       sensor_zero;
    } remote_prog_t;

    // Programming lines toward the controller, active low, wired-OR style
    typedef struct packed {
        logic [2:0] range_sel_n;
        logic [1:0] mode_sel_n;
        logic       cal_factor_disable_n;
        logic       sensor_zero_n;
    } ctrl_prog_t;

    // Print strobe state
    typedef enum logic {
        STROBE_HIGH = 1'h0,
        STROBE_LOW  = 1'h1
    } strobe_state_t;

endpackage

// ===== design/bcd_remote_program_port.sv
// Remote programming and data output port between external controller and program controller
// Summary of operation
// - Remote enable low opens range, mode and qualifier gates for remote control.
// - In remote operation drive local/remote status output low.
// - Remote enable high closes gates, except sensor zero with the option set, and drives local/remote status high.
// - Remote and panel outputs combine wired-OR; idle source sits high.
// - Output buffers always present inverted measurement and status values.
// - Data valid instruction drives print strobe low.
// - Cycle start instruction returns print strobe high.
// - Three remote range inputs are always buffered to range outputs.
// - Range counter loads only at cycle start, remote, auto inactive.
// - Range bits 2 and 3 high while remote drive auto-range low.
// - In local operation auto-range output stays high.
// - Range code zero while remote drives program hold low.
// - Mode and cal disable pass only while remote enable low; sensor zero also passes in local with the option set.
// - Remote enable high forces mode gate outputs high.
// - Option lets remote sensor zero act even in local operation.
`timescale 1ns/100ps

`include "remote_port_cfg.svh"

module bcd_remote_program_port #(
    parameter int DATA_W   = `DATA_W,
    parameter int STATUS_W = `STATUS_W
) (
    input  wire logic                          ref_clk,
    input  wire logic                          nrst,
    // Connector side, asynchronous to ref_clk
    input  wire logic                          remote_enable,
    input  wire remote_port_pkg::remote_prog_t remote_prog,
    output logic      [DATA_W-1:0]             meas_out_n,
    output logic      [STATUS_W-1:0]           status_out_n,
    output logic                               print_n,
    // Configuration strap
    input  wire logic                          sensor_zero_indep,
    // Front panel switches, active low
    input  wire remote_port_pkg::ctrl_prog_t   panel_prog_n,
    input  wire logic                          panel_range_hold_n,
    // Program controller side
    input  wire logic                          data_valid_instruction,
    input  wire logic                          cycle_start_instruction,
    input  wire logic      [DATA_W-1:0]        meas_in,
    input  wire logic      [STATUS_W-1:0]      status_in,
    input  wire logic      [2:0]               range_count_in,
    output logic                               local_remote_status_n,
    output logic                               remote_range_out_1,
    output logic                               remote_range_out_2,
    output logic                               remote_range_out_3,
    output logic                               auto_range_select_n,
    output logic                               program_hold_n,
    output remote_port_pkg::ctrl_prog_t        ctrl_prog_n,
    output logic                               remote_gate_en,
    output logic                               range_load,
    output logic      [2:0]                    range_count_r
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic                         rem_en_s1_r;
    logic                         rem_en_r;
    remote_port_pkg::remote_prog_t prog_s1_r;
    remote_port_pkg::remote_prog_t prog_r;
    remote_port_pkg::ctrl_prog_t   panel_s1_r;
    remote_port_pkg::ctrl_prog_t   panel_r;
    logic                          hold_s1_r;
    logic                          hold_r;
    logic                          sz_indep_s1_r;
    logic                          sz_indep_r;

    // Two stages for every connector input
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rem_en_s1_r <= 1'h1;
            rem_en_r    <= 1'h1;
            prog_s1_r   <= '0;
            prog_r      <= '0;
        end else begin
            rem_en_s1_r <= remote_enable;
            rem_en_r    <= rem_en_s1_r;
            prog_s1_r   <= remote_prog;
            prog_r      <= prog_s1_r;
        end
    end

    // Panel switches and option strap are asynchronous too; two stages keep a bounce from splitting a decode
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            panel_s1_r    <= '1;
            panel_r       <= '1;
            hold_s1_r     <= `OUT_INACTIVE;
            hold_r        <= `OUT_INACTIVE;
            sz_indep_s1_r <= 1'h0;
            sz_indep_r    <= 1'h0;
        end else begin
            panel_s1_r    <= panel_prog_n;
            panel_r       <= panel_s1_r;
            hold_s1_r     <= panel_range_hold_n;
            hold_r        <= hold_s1_r;
            sz_indep_s1_r <= sensor_zero_indep;
            sz_indep_r    <= sz_indep_s1_r;
        end
    end

    // ==========================================================
    // Local / remote selection and range gates
    // ==========================================================
    logic remote_sel;
    logic auto_n_int;

    assign remote_sel     = ~rem_en_r;
    assign remote_gate_en = remote_sel;

    // Status output and range decodes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            local_remote_status_n <= `OUT_INACTIVE;
            auto_range_select_n   <= `OUT_INACTIVE;
            program_hold_n        <= `OUT_INACTIVE;
            remote_range_out_1    <= 1'h0;
            remote_range_out_2    <= 1'h0;
            remote_range_out_3    <= 1'h0;
        end else begin
            local_remote_status_n <= rem_en_r;
            remote_range_out_1    <= prog_r.range_bits[0];
            remote_range_out_2    <= prog_r.range_bits[1];
            remote_range_out_3    <= prog_r.range_bits[2];
            // Auto range decode, held high in local
            auto_range_select_n   <= ~(remote_sel & prog_r.range_bits[1] & prog_r.range_bits[2]);
            // Range zero parks the program at its start address
            program_hold_n        <= ~(remote_sel && prog_r.range_bits == `RANGE_HOLD_CODE);
        end
    end

    // ==========================================================
    // Range counter load
    // ==========================================================
    assign auto_n_int = auto_range_select_n & hold_r;
    assign range_load = cycle_start_instruction & ~local_remote_status_n & auto_n_int;

    // Range counter, remote value at cycle start or controller value
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            range_count_r <= 3'h0;
        end else if (range_load) begin
            range_count_r <= {remote_range_out_3, remote_range_out_2, remote_range_out_1};
        end else begin
            range_count_r <= range_count_in;
        end
    end

    // ==========================================================
    // Mode gates and wired-OR combine
    // ==========================================================
    remote_port_pkg::ctrl_prog_t remote_lines_n;
    logic                        zero_en;

    assign zero_en = remote_sel | sz_indep_r;

    // Remote lines are high when their gate is closed
    always_comb begin
        remote_lines_n.range_sel_n          = remote_sel ? ~prog_r.range_bits : 3'h7;
        remote_lines_n.mode_sel_n           = remote_sel ? ~prog_r.mode_bits : 2'h3;
        remote_lines_n.cal_factor_disable_n = remote_sel ? ~prog_r.cal_factor_disable
                                                         : `OUT_INACTIVE;
        remote_lines_n.sensor_zero_n        = zero_en ? ~prog_r.sensor_zero
                                                      : `OUT_INACTIVE;
    end

    // Active-low wired-OR with panel switches, registered
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_prog_n <= '1;
        end else begin
            ctrl_prog_n <= remote_lines_n & panel_r;
        end
    end

    // ==========================================================
    // Output data buffers and print strobe
    // ==========================================================
    remote_port_pkg::strobe_state_t strobe_r;

    // Inverted copies always driven
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meas_out_n   <= '1;
            status_out_n <= '1;
        end else begin
            meas_out_n   <= ~meas_in;
            status_out_n <= ~status_in;
        end
    end

    // Strobe low on data valid, high on next cycle start
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strobe_r <= remote_port_pkg::STROBE_HIGH;
        end else begin
            unique case (strobe_r)
                remote_port_pkg::STROBE_HIGH: begin
                    if (data_valid_instruction) begin
                        strobe_r <= remote_port_pkg::STROBE_LOW;
                    end
                end
                remote_port_pkg::STROBE_LOW: begin
                    if (cycle_start_instruction) begin
                        strobe_r <= remote_port_pkg::STROBE_HIGH;
                    end
                end
            endcase
        end
    end

    assign print_n = (strobe_r == remote_port_pkg::STROBE_LOW) ? `STROBE_ACTIVE : `STROBE_IDLE;

    // ==========================================================
    // Checks
    // ==========================================================
    strobe_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (print_n && data_valid_instruction) |=> !print_n)
        else $error("print strobe did not fall on data valid");

    strobe_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!print_n && cycle_start_instruction) |=> print_n)
        else $error("print strobe did not rise on cycle start");

    strobe_stays_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!print_n && !cycle_start_instruction) |=> !print_n)
        else $error("print strobe rose without cycle start");

    strobe_stays_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (print_n && !data_valid_instruction) |=> print_n)
        else $error("print strobe fell without data valid");

    status_remote_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        remote_sel |=> !local_remote_status_n)
        else $error("status not low in remote");

    status_local_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !remote_sel |=> local_remote_status_n)
        else $error("status not high in local");

    auto_decode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && prog_r.range_bits[2:1] == 2'h3) |=> !auto_range_select_n)
        else $error("auto range not selected for codes 6 and 7");

    auto_other_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && prog_r.range_bits[2:1] != 2'h3) |=> auto_range_select_n)
        else $error("auto range selected for a fixed range code");

    auto_local_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !remote_sel |=> auto_range_select_n)
        else $error("auto range low in local");

    hold_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && prog_r.range_bits == 3'h0) |=> !program_hold_n)
        else $error("program hold not asserted for range zero");

    hold_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && prog_r.range_bits != 3'h0) |=> program_hold_n)
        else $error("program hold asserted for a nonzero range code");

    hold_local_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !remote_sel |=> program_hold_n)
        else $error("program hold asserted in local");

    mode_forced_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!remote_sel && panel_r.mode_sel_n == 2'h3) |=> ctrl_prog_n.mode_sel_n == 2'h3)
        else $error("mode lines not released in local");

    cal_forced_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!remote_sel && panel_r.cal_factor_disable_n) |=> ctrl_prog_n.cal_factor_disable_n)
        else $error("cal factor line not released in local");

    mode_pass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && panel_r.mode_sel_n == 2'h3) |=> ctrl_prog_n.mode_sel_n == ~$past(prog_r.mode_bits))
        else $error("remote mode not passed in remote");

    zero_indep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (sz_indep_r && prog_r.sensor_zero) |=> !ctrl_prog_n.sensor_zero_n)
        else $error("remote sensor zero ignored with option set");

    zero_local_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!remote_sel && !sz_indep_r && panel_r.sensor_zero_n) |=> ctrl_prog_n.sensor_zero_n)
        else $error("remote sensor zero passed in local");

    wired_or_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (panel_r.range_sel_n == 3'h0) |=> ctrl_prog_n.range_sel_n == 3'h0)
        else $error("panel range lines not combined");

    range_closed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!remote_sel && panel_r.range_sel_n == 3'h7) |=> ctrl_prog_n.range_sel_n == 3'h7)
        else $error("range lines not released in local");

    range_open_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (remote_sel && panel_r.range_sel_n == 3'h7) |=> ctrl_prog_n.range_sel_n == ~$past(prog_r.range_bits))
        else $error("remote range not passed in remote");

    range_buf_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'h1 |=> remote_range_out_3 == $past(prog_r.range_bits[2]))
        else $error("range bit not buffered");

    range_buf_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'h1 |=> {remote_range_out_2, remote_range_out_1} == $past(prog_r.range_bits[1:0]))
        else $error("low range bits not buffered");

    load_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        range_load |-> (cycle_start_instruction && !local_remote_status_n && auto_range_select_n))
        else $error("range loaded outside remote cycle start");

    load_value_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        range_load |=> range_count_r == $past({remote_range_out_3, remote_range_out_2, remote_range_out_1}))
        else $error("range counter did not take the remote range");

    meas_inv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'h1 |=> meas_out_n == ~$past(meas_in))
        else $error("measurement output not inverted copy");

    status_inv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'h1 |=> status_out_n == ~$past(status_in))
        else $error("status output not inverted copy");

endmodule

// ===== test/ext_controller.sv
// External controller model on the remote connector
`timescale 1ns/100ps

module ext_controller #(
    parameter int DATA_W = 16
) (
    input  wire logic                      ref_clk,
    input  wire logic                      print_n,
    input  wire logic [DATA_W-1:0]         meas_out_n,
    output logic                           remote_enable,
    output remote_port_pkg::remote_prog_t  remote_prog,
    output logic [DATA_W-1:0]              captured_n
);
    // Idle connector: local operation, programming lines low
    initial begin
        remote_enable = 1'h1;
        remote_prog   = '0;
        captured_n    = '0;
    end

    // Connector levels are set by the bench just after a falling edge
    task automatic drive(input logic en, input remote_port_pkg::remote_prog_t p);
        remote_enable = en;
        remote_prog   = p;
    endtask

    // Measurement is taken only inside the strobe window
    always @(posedge ref_clk) begin
        if (print_n == 1'h0) begin
            captured_n <= meas_out_n;
        end
    end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the remote program port
`timescale 1ns/100ps

module tb_top;
    logic                          ref_clk, nrst, sensor_zero_indep, panel_range_hold_n;
    logic                          data_valid_instruction, cycle_start_instruction, remote_enable;
    logic                          local_remote_status_n, auto_range_select_n, program_hold_n, print_n;
    logic                          remote_range_out_1, remote_range_out_2, remote_range_out_3;
    logic                          remote_gate_en, range_load;
    logic [15:0]                   meas_in, meas_out_n, captured_n;
    logic [3:0]                    status_in, status_out_n;
    logic [2:0]                    range_count_in, range_count_r;
    remote_port_pkg::remote_prog_t remote_prog;
    remote_port_pkg::ctrl_prog_t   panel_prog_n, ctrl_prog_n;
    logic                          sq[$];
    logic [53:0]                   lq[$];
    event                          level_ev;
    int                            err_total = 0;
    int                            samples_checked = 0;

    ext_controller pm (.ref_clk(ref_clk), .print_n(print_n), .meas_out_n(meas_out_n),
        .remote_enable(remote_enable), .remote_prog(remote_prog), .captured_n(captured_n));

    bcd_remote_program_port dut (.ref_clk(ref_clk), .nrst(nrst), .remote_enable(remote_enable),
        .remote_prog(remote_prog), .meas_out_n(meas_out_n), .status_out_n(status_out_n),
        .print_n(print_n), .sensor_zero_indep(sensor_zero_indep), .panel_prog_n(panel_prog_n),
        .panel_range_hold_n(panel_range_hold_n), .data_valid_instruction(data_valid_instruction),
        .cycle_start_instruction(cycle_start_instruction), .meas_in(meas_in), .status_in(status_in),
        .range_count_in(range_count_in), .local_remote_status_n(local_remote_status_n),
        .remote_range_out_1(remote_range_out_1), .remote_range_out_2(remote_range_out_2),
        .remote_range_out_3(remote_range_out_3), .auto_range_select_n(auto_range_select_n),
        .program_hold_n(program_hold_n), .ctrl_prog_n(ctrl_prog_n), .remote_gate_en(remote_gate_en),
        .range_load(range_load), .range_count_r(range_count_r));

    // ==========================================
    // Compare and closing tasks
    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic chk_vec(input string n, input logic [19:0] e, input logic [19:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Clock, watchdog and result watchers
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #20000;
        err_total++;
        summarize();
    end

    // Each strobe edge takes the oldest strobe note
    always @(print_n) begin
        if (nrst === 1'h1) begin
            if (sq.size() == 0) chk_bit("print_n spurious", ~print_n, print_n);
            else chk_bit("print_n", sq.pop_front(), print_n);
        end
    end

    // Settled port levels against the oldest level note
    always begin : level_watch
        logic [53:0] e;
        @(level_ev);
        e = lq.pop_front();
        chk_vec("status decodes", 20'({e[53], e[49:48]}), 20'({local_remote_status_n, auto_range_select_n,
            program_hold_n}));
        chk_vec("range outputs", 20'(e[52:50]),
            20'({remote_range_out_3, remote_range_out_2, remote_range_out_1}));
        chk_vec("controller lines", 20'(e[47:40]),
            20'({ctrl_prog_n, remote_gate_en}));
        chk_vec("range counter", 20'(e[39:37]), 20'(range_count_r));
        chk_vec("data buffers", e[36:17], {meas_out_n, status_out_n});
        chk_bit("print level", e[16], print_n);
        chk_vec("captured data", 20'(e[15:0]), 20'(captured_n));
    end

    // ==========================================
    // Stimulus: every range code in remote, then random mixes
    initial begin : stim
        int                            i;
        logic                          en, cs, dv, rem, ld, st;
        logic [31:0]                   seed_v;
        logic [15:0]                   cap;
        remote_port_pkg::remote_prog_t p;
        remote_port_pkg::ctrl_prog_t   g;
        nrst = 1'h0; sensor_zero_indep = 1'h0; panel_range_hold_n = 1'h1;
        data_valid_instruction = 1'h0; cycle_start_instruction = 1'h0;
        meas_in = 16'h0; status_in = 4'h0; range_count_in = 3'h0; panel_prog_n = 7'h7F;
        st = 1'h1;
        cap = 16'h0;
        seed_v = $urandom(32'h0652);
        repeat (6) @(negedge ref_clk);
        nrst = 1'h1;
        for (i = 0; i < 40; i++) begin
            @(negedge ref_clk);
            en = (i < 8) ? 1'h0 : 1'($urandom);
            p = 7'($urandom);
            if (i < 8) p.range_bits = 3'(i);
            pm.drive(en, p);
            panel_prog_n = 7'($urandom); sensor_zero_indep = 1'($urandom);
            panel_range_hold_n = 1'($urandom); meas_in = 16'($urandom);
            status_in = 4'($urandom); range_count_in = 3'($urandom);
            repeat (4) @(negedge ref_clk);
            cs = 1'($urandom);
            dv = 1'($urandom);
            cycle_start_instruction = cs;
            data_valid_instruction = dv;
            // Controller keeps the last data seen while the strobe was low
            if (!st) cap = ~meas_in;
            if (!st && cs) begin
                st = 1'h1;
                sq.push_back(1'h1);
            end else if (st && dv) begin
                st = 1'h0;
                sq.push_back(1'h0);
            end
            @(negedge ref_clk);
            cycle_start_instruction = 1'h0;
            data_valid_instruction = 1'h0;
            rem = ~en;
            g.range_sel_n = rem ? ~p.range_bits : 3'h7;
            g.mode_sel_n = rem ? ~p.mode_bits : 2'h3;
            g.cal_factor_disable_n = ~(rem & p.cal_factor_disable);
            g.sensor_zero_n = ~((rem | sensor_zero_indep) & p.sensor_zero);
            ld = cs & rem & ~(p.range_bits[2] & p.range_bits[1]) & panel_range_hold_n;
            lq.push_back({en, p.range_bits[2], p.range_bits[1], p.range_bits[0],
                ~(rem & p.range_bits[2] & p.range_bits[1]), ~(rem & (p.range_bits == 3'h0)),
                7'(g) & 7'(panel_prog_n), rem, ld ? p.range_bits : range_count_in, ~meas_in, ~status_in, st, cap});
            -> level_ev;
            if (i == 7) $display("test remote range codes done");
        end
        repeat (3) @(negedge ref_clk);
        chk_bit("strobe notes left", 1'h1, sq.size() == 0);
        $display("test random mixes done");
        summarize();
    end
endmodule
